// *** verilog/async_bus_pkg.sv ***
// Constants, cycle kinds and timing for the asynchronous multiplexed bus master
package async_bus_pkg;

  localparam int CLK_MHZ     = 200;
  localparam int CNT_W       = 12;
  localparam int REF_W       = 20;
  localparam int SYNC_N      = 6;

  // Times in their own units, converted to core clock cycles
  localparam int TIMEOUT_US  = 10;
  localparam int INIT_US     = 10;
  localparam int SETUP_NS    = 50;
  localparam int PAUSE_NS    = 100;
  localparam int REFRESH_MS  = 2;
  localparam int TIMEOUT_I   = TIMEOUT_US * CLK_MHZ;
  localparam int INIT_I      = INIT_US * CLK_MHZ;
  localparam int SETUP_I     = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PAUSE_I     = (PAUSE_NS * CLK_MHZ + 999) / 1000;
  localparam int REFRESH_I   = REFRESH_MS * 1000 * CLK_MHZ;
  localparam logic [CNT_W-1:0] TIMEOUT_CYC = CNT_W'(TIMEOUT_I);
  localparam logic [CNT_W-1:0] INIT_CYC    = CNT_W'(INIT_I);
  localparam logic [CNT_W-1:0] SETUP_CYC   = CNT_W'(SETUP_I);
  localparam logic [CNT_W-1:0] PAUSE_CYC   = CNT_W'(PAUSE_I);

  // Refresh burst
  localparam logic [6:0]  REFRESH_COUNT = 7'h40;
  localparam logic [8:0]  REF_ADDR_HI   = 9'h000;

  // Upper bank decode on address bits 15:13
  localparam int          BANK_LSB      = 13;
  localparam logic [2:0]  BANK_TOP      = 3'h7;

  // Status word interrupt gate
  localparam int          PRIO_BIT      = 7;

  // Trap locations
  localparam logic [15:0] TRAP_TIMEOUT  = 16'h0004;
  localparam logic [15:0] TRAP_EVENT    = 16'h0040;
  localparam logic [15:0] TRAP_PFAIL_PC = 16'h00A6;
  localparam logic [15:0] TRAP_PFAIL_PS = 16'h00B6;

  // Synchroniser slots
  localparam int SY_REPLY = 0;
  localparam int SY_IRQ   = 1;
  localparam int SY_HALT  = 2;
  localparam int SY_DCOK  = 3;
  localparam int SY_POK   = 4;
  localparam int SY_EVENT = 5;

  typedef enum logic [2:0] {
    CYC_READ, CYC_WRITE, CYC_WRITE_BYTE, CYC_RMW, CYC_RMW_BYTE, CYC_REFRESH
  } cyc_kind_t;

  typedef enum {
    S_IDLE, S_ADDR, S_SYNC, S_DIN, S_DIN_END, S_DOUT_SET, S_DOUT, S_DOUT_END,
    S_REL, S_IACK_PAUSE, S_IACK, S_INIT
  } bus_state_t;

endpackage : async_bus_pkg

// *** verilog/async_bus_master.sv ***
// Bus master for the asynchronous interlocked multiplexed address/data bus
// Behaviour
// - read: address, bank select, sync, no byteflag
// - read data: din, reply, drop din, sync
// - no reply to din in 10us: trap 4
// - read-modify-write keeps sync through output transfer
// - rmw byte: byteflag with dout, drop at end
// - write: byteflag in address phase
// - write data: dout, reply, drop dout, sync
// - no reply to dout in 10us: trap 4
// - byte write keeps byteflag; word write drops it
// - interrupts only at boundary with status bit7 clear
// - priority 4 disables, 0 enables interrupts
// - acknowledge: din without sync, pause, chain out
// - after vector drop din and chain out
// - nearest device on chain wins
// - event line traps through fixed location
// - reset instruction drives bus_init about 10us
// - power-up: init until dc_ok, then power_ok, halt
// - power_ok fall traps; dc_ok fall drives init
// - refresh: 64 strobed reads per 2ms, row count
`timescale 1ns/1ps
`default_nettype none

module async_bus_master
  import async_bus_pkg::*;
#(
  parameter int REFRESH_PERIOD_CYC = async_bus_pkg::REFRESH_I
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  // Core command port
  input  wire logic                   cmdValid,
  output logic                        cmdReady,
  input  wire async_bus_pkg::cyc_kind_t cmdKind,
  input  wire logic [15:0]            cmdAddr,
  input  wire logic [15:0]            cmdWdata,
  output logic                        doneValid,
  output logic [15:0]                 doneData,
  // Core control and traps
  input  wire logic                   instrBoundary,
  input  wire logic [15:0]            statusWord,
  input  wire logic                   resetCmd,
  output logic                        trapValid,
  output logic [15:0]                 trapVector,
  output logic [15:0]                 trapStatusLoc,
  output logic                        startValid,
  output logic                        startConsole,
  // Bus address/data lines
  input  wire logic [15:0]            addrDataIn,
  output logic [15:0]                 addrDataOut,
  output logic                        addrDataOe,
  // Bus control, asserted high here
  output logic                        syncStrobe,
  output logic                        dataInStrobe,
  output logic                        dataOutStrobe,
  output logic                        writeByteFlag,
  output logic                        upperBankSelect,
  output logic                        refreshStrobe,
  output logic                        ackChainOut,
  output logic                        busInit,
  input  wire logic                   replyAck,
  input  wire logic                   irqRequest,
  input  wire logic                   haltRequest,
  input  wire logic                   dcOk,
  input  wire logic                   powerOk,
  input  wire logic                   eventLine
);
  import async_bus_pkg::*;

  // Two-stage synchronisers for every asynchronous control input; addrDataIn is sampled directly
  logic [SYNC_N-1:0] rawIn;
  logic [SYNC_N-1:0] meta_r;
  logic [SYNC_N-1:0] sync_r;
  assign rawIn = {eventLine, powerOk, dcOk, haltRequest, irqRequest, replyAck};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (sys_rst) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= rawIn[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  logic replyS;
  logic irqS;
  logic dcOkS;
  logic pokS;
  assign replyS = sync_r[SY_REPLY];
  assign irqS   = sync_r[SY_IRQ];
  assign dcOkS  = sync_r[SY_DCOK];
  assign pokS   = sync_r[SY_POK];

  // Power, event and refresh timing state
  logic             pokPrev_r, pokPrev_nxt;
  logic             eventPrev_r, eventPrev_nxt;
  logic             run_r, run_nxt;
  logic             startValid_r, startValid_nxt;
  logic             startConsole_r, startConsole_nxt;
  logic [REF_W-1:0] refTimer_r, refTimer_nxt;
  logic             pokFall;
  logic             eventRise;
  logic             refTick;

  always_comb begin
    pokPrev_nxt      = pokS;
    eventPrev_nxt    = sync_r[SY_EVENT];
    pokFall          = pokPrev_r && !pokS;
    eventRise        = sync_r[SY_EVENT] && !eventPrev_r;
    startValid_nxt   = 1'b0;
    startConsole_nxt = startConsole_r;
    run_nxt          = run_r;
    refTick          = (refTimer_r == REF_W'(REFRESH_PERIOD_CYC - 1));
    refTimer_nxt     = refTick ? '0 : refTimer_r + REF_W'(1);
    if (!dcOkS) begin
      run_nxt = 1'b0;
    end else if (pokS && !pokPrev_r) begin
      run_nxt          = 1'b1;
      startValid_nxt   = 1'b1;
      startConsole_nxt = sync_r[SY_HALT];
    end else if (pokFall) begin
      run_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pokPrev_r      <= 1'b0;
      eventPrev_r    <= 1'b0;
      run_r          <= 1'b0;
      startValid_r   <= 1'b0;
      startConsole_r <= 1'b0;
      refTimer_r     <= '0;
    end else begin
      pokPrev_r      <= pokPrev_nxt;
      eventPrev_r    <= eventPrev_nxt;
      run_r          <= run_nxt;
      startValid_r   <= startValid_nxt;
      startConsole_r <= startConsole_nxt;
      refTimer_r     <= refTimer_nxt;
    end
  end

  // Bus sequencer state
  bus_state_t       st_r, st_nxt;
  cyc_kind_t        kind_r, kind_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [15:0]      wdata_r, wdata_nxt;
  logic [15:0]      adOut_r, adOut_nxt;
  logic             adOe_r, adOe_nxt;
  logic             sync_o_r, sync_o_nxt;
  logic             din_r, din_nxt;
  logic             dout_r, dout_nxt;
  logic             wbf_r, wbf_nxt;
  logic             bank_r, bank_nxt;
  logic             refS_r, refS_nxt;
  logic             ack_r, ack_nxt;
  logic             init_r, init_nxt;
  logic             done_r, done_nxt;
  logic [15:0]      doneData_r, doneData_nxt;
  logic             trap_r, trap_nxt;
  logic [15:0]      trapVec_r, trapVec_nxt;
  logic [15:0]      trapPs_r, trapPs_nxt;
  logic [6:0]       refLeft_r, refLeft_nxt;
  logic [5:0]       refRow_r, refRow_nxt;
  logic             pfPend_r, pfPend_nxt;
  logic             evPend_r, evPend_nxt;
  logic             rstPend_r, rstPend_nxt;
  logic             intrOk;
  logic             kindIn;
  logic             kindByte;
  logic             kindRmw;
  logic             timedOut;

  assign intrOk   = run_r && instrBoundary && !statusWord[PRIO_BIT];
  assign kindIn   = (kind_r == CYC_READ) || (kind_r == CYC_RMW) || (kind_r == CYC_RMW_BYTE) || (kind_r == CYC_REFRESH);
  assign kindByte = (kind_r == CYC_WRITE_BYTE) || (kind_r == CYC_RMW_BYTE);
  assign kindRmw  = (kind_r == CYC_RMW) || (kind_r == CYC_RMW_BYTE);
  assign timedOut = (cnt_r == TIMEOUT_CYC - CNT_W'(1)) && !replyS;
  assign cmdReady = (st_r == S_IDLE) && run_r && !pfPend_r && !rstPend_r && !resetCmd && (refLeft_r == '0)
                    && !(intrOk && (evPend_r || irqS));

  always_comb begin
    st_nxt = st_r; kind_nxt = kind_r; wdata_nxt = wdata_r;
    adOut_nxt = adOut_r; adOe_nxt = adOe_r; sync_o_nxt = sync_o_r;
    din_nxt = din_r; dout_nxt = dout_r; wbf_nxt = wbf_r; bank_nxt = bank_r;
    refS_nxt = refS_r; ack_nxt = ack_r; doneData_nxt = doneData_r;
    trapVec_nxt = trapVec_r; trapPs_nxt = trapPs_r; refRow_nxt = refRow_r;
    cnt_nxt = cnt_r + CNT_W'(1);
    done_nxt = 1'b0;
    trap_nxt = 1'b0;
    refLeft_nxt = refLeft_r;
    pfPend_nxt  = pfPend_r;
    evPend_nxt  = evPend_r;
    rstPend_nxt = rstPend_r || resetCmd;
    unique case (st_r)
      S_IDLE: begin
        cnt_nxt = '0;
        if (pfPend_r) begin
          pfPend_nxt = 1'b0;
          trap_nxt = 1'b1; trapVec_nxt = TRAP_PFAIL_PC; trapPs_nxt = TRAP_PFAIL_PS;
        end else if (rstPend_r) begin
          rstPend_nxt = resetCmd;
          st_nxt = S_INIT;
        end else if (refLeft_r != '0 && dcOkS) begin
          kind_nxt = CYC_REFRESH; st_nxt = S_ADDR;
          adOut_nxt = {REF_ADDR_HI, refRow_r, 1'b0}; adOe_nxt = 1'b1;
          refS_nxt = 1'b1;
        end else if (intrOk && evPend_r) begin
          evPend_nxt = 1'b0;
          trap_nxt = 1'b1; trapVec_nxt = TRAP_EVENT; trapPs_nxt = TRAP_EVENT + 16'h0002;
        end else if (intrOk && irqS) begin
          din_nxt = 1'b1; st_nxt = S_IACK_PAUSE;
        end else if (cmdValid && cmdReady) begin
          kind_nxt = cmdKind; wdata_nxt = cmdWdata; st_nxt = S_ADDR;
          adOut_nxt = cmdAddr; adOe_nxt = 1'b1;
          bank_nxt = (cmdAddr[15:BANK_LSB] == BANK_TOP);
          wbf_nxt = (cmdKind == CYC_WRITE) || (cmdKind == CYC_WRITE_BYTE);
        end
      end
      S_ADDR: if (cnt_r == SETUP_CYC) begin
        sync_o_nxt = 1'b1; cnt_nxt = '0; st_nxt = S_SYNC;
      end
      S_SYNC: if (cnt_r == SETUP_CYC) begin
        cnt_nxt = '0; bank_nxt = 1'b0; refS_nxt = 1'b0;
        if (kindIn) begin
          adOe_nxt = 1'b0; din_nxt = 1'b1; st_nxt = S_DIN;
        end else begin
          adOut_nxt = wdata_r; wbf_nxt = kindByte; st_nxt = S_DOUT_SET;
        end
      end
      S_DIN: if (replyS) begin
        doneData_nxt = addrDataIn; din_nxt = 1'b0; st_nxt = S_DIN_END;
      end else if (timedOut) begin
        sync_o_nxt = 1'b0; din_nxt = 1'b0; wbf_nxt = 1'b0; st_nxt = S_REL;
        trap_nxt = 1'b1; trapVec_nxt = TRAP_TIMEOUT; trapPs_nxt = TRAP_TIMEOUT + 16'h0002;
      end
      S_DIN_END: begin
        cnt_nxt = '0;
        if (kind_r == CYC_REFRESH) begin
          sync_o_nxt = 1'b0; st_nxt = S_REL;
          refRow_nxt = refRow_r + 6'h01; refLeft_nxt = refLeft_r - 7'h01;
        end else if (!kindRmw) begin
          sync_o_nxt = 1'b0; done_nxt = 1'b1; st_nxt = S_REL;
        end else if (!replyS) begin
          adOut_nxt = wdata_r; adOe_nxt = 1'b1; wbf_nxt = kindByte; st_nxt = S_DOUT_SET;
        end
      end
      S_DOUT_SET: begin
        adOe_nxt = 1'b1;
        if (cnt_r == SETUP_CYC) begin
          dout_nxt = 1'b1; cnt_nxt = '0; st_nxt = S_DOUT;
        end
      end
      S_DOUT: if (replyS) begin
        dout_nxt = 1'b0; adOe_nxt = 1'b0; st_nxt = S_DOUT_END;
      end else if (timedOut) begin
        sync_o_nxt = 1'b0; dout_nxt = 1'b0; adOe_nxt = 1'b0; wbf_nxt = 1'b0; st_nxt = S_REL;
        trap_nxt = 1'b1; trapVec_nxt = TRAP_TIMEOUT; trapPs_nxt = TRAP_TIMEOUT + 16'h0002;
      end
      S_DOUT_END: if (!replyS) begin
        sync_o_nxt = 1'b0; wbf_nxt = 1'b0; done_nxt = 1'b1; st_nxt = S_IDLE;
      end
      S_REL: if (!replyS) st_nxt = S_IDLE;
      S_IACK_PAUSE: if (cnt_r == PAUSE_CYC) begin
        ack_nxt = 1'b1; cnt_nxt = '0; st_nxt = S_IACK;
      end
      S_IACK: if (replyS) begin
        din_nxt = 1'b0; ack_nxt = 1'b0; st_nxt = S_REL;
        trap_nxt = 1'b1; trapVec_nxt = addrDataIn; trapPs_nxt = addrDataIn + 16'h0002;
      end else if (timedOut) begin
        din_nxt = 1'b0; ack_nxt = 1'b0; st_nxt = S_REL;
        trap_nxt = 1'b1; trapVec_nxt = TRAP_TIMEOUT; trapPs_nxt = TRAP_TIMEOUT + 16'h0002;
      end
      S_INIT: if (cnt_r == INIT_CYC - CNT_W'(1)) st_nxt = S_IDLE;
    endcase
    // Events arriving alongside their clear are kept
    if (refTick) refLeft_nxt = REFRESH_COUNT;
    if (pokFall) pfPend_nxt = 1'b1;
    if (eventRise) evPend_nxt = 1'b1;
    init_nxt = !dcOkS || (st_nxt == S_INIT);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= S_IDLE; kind_r <= CYC_READ; cnt_r <= '0; wdata_r <= '0;
      adOut_r <= '0; adOe_r <= 1'b0; sync_o_r <= 1'b0; din_r <= 1'b0;
      dout_r <= 1'b0; wbf_r <= 1'b0; bank_r <= 1'b0; refS_r <= 1'b0;
      ack_r <= 1'b0; init_r <= 1'b1; done_r <= 1'b0; doneData_r <= '0;
      trap_r <= 1'b0; trapVec_r <= '0; trapPs_r <= '0; refLeft_r <= '0;
      refRow_r <= '0; pfPend_r <= 1'b0; evPend_r <= 1'b0; rstPend_r <= 1'b0;
    end else begin
      st_r <= st_nxt; kind_r <= kind_nxt; cnt_r <= cnt_nxt; wdata_r <= wdata_nxt;
      adOut_r <= adOut_nxt; adOe_r <= adOe_nxt; sync_o_r <= sync_o_nxt; din_r <= din_nxt;
      dout_r <= dout_nxt; wbf_r <= wbf_nxt; bank_r <= bank_nxt; refS_r <= refS_nxt;
      ack_r <= ack_nxt; init_r <= init_nxt; done_r <= done_nxt; doneData_r <= doneData_nxt;
      trap_r <= trap_nxt; trapVec_r <= trapVec_nxt; trapPs_r <= trapPs_nxt; refLeft_r <= refLeft_nxt;
      refRow_r <= refRow_nxt; pfPend_r <= pfPend_nxt; evPend_r <= evPend_nxt; rstPend_r <= rstPend_nxt;
    end
  end

  assign addrDataOut     = adOut_r;
  assign addrDataOe      = adOe_r;
  assign syncStrobe      = sync_o_r;
  assign dataInStrobe    = din_r;
  assign dataOutStrobe   = dout_r;
  assign writeByteFlag   = wbf_r;
  assign upperBankSelect = bank_r;
  assign refreshStrobe   = refS_r;
  assign ackChainOut     = ack_r;
  assign busInit         = init_r;
  assign doneValid       = done_r;
  assign doneData        = doneData_r;
  assign trapValid       = trap_r;
  assign trapVector      = trapVec_r;
  assign trapStatusLoc   = trapPs_r;
  assign startValid      = startValid_r;
  assign startConsole    = startConsole_r;

  a_addr_before_sync: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(syncStrobe) |-> addrDataOe && $past(addrDataOe) && !dataInStrobe)
    else $error("sync raised without address on lines");
  a_din_before_sync_drop: assert property (@(posedge core_clk) disable iff (sys_rst)
    $fell(syncStrobe) && !trapValid |-> !dataInStrobe && !dataOutStrobe && !$past(dataInStrobe))
    else $error("sync dropped before data strobe ended");
  a_din_timeout: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_r == S_DIN && cnt_r == TIMEOUT_CYC - CNT_W'(1) && !replyS
    |=> trapValid && trapVector == TRAP_TIMEOUT && !syncStrobe)
    else $error("read timeout did not trap");
  a_rmw_sync_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(dataOutStrobe) |-> syncStrobe && !upperBankSelect && !refreshStrobe)
    else $error("output transfer without sync held");
  a_write_flag_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(syncStrobe) |-> writeByteFlag == !kindIn)
    else $error("byte flag wrong in address phase");
  a_dout_timeout: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_r == S_DOUT && cnt_r == TIMEOUT_CYC - CNT_W'(1) && !replyS |=> trapValid && !dataOutStrobe && !syncStrobe)
    else $error("write timeout did not trap");
  a_byte_flag_data: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataOutStrobe |-> writeByteFlag == kindByte)
    else $error("byte flag wrong during output transfer");
  a_iack_no_sync: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(ackChainOut) |-> !syncStrobe && dataInStrobe && $past(dataInStrobe, 2))
    else $error("acknowledge without lone data-in strobe");
  a_iack_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(dataInStrobe) && !syncStrobe |-> $past(!statusWord[PRIO_BIT] && instrBoundary))
    else $error("interrupt taken while disabled");
  a_init_length: assert property (@(posedge core_clk) disable iff (sys_rst)
    st_r == S_INIT && dcOkS && cnt_r == INIT_CYC - CNT_W'(1) |=> st_r == S_IDLE && !busInit)
    else $error("reset init length wrong");
  a_refresh_addr: assert property (@(posedge core_clk) disable iff (sys_rst)
    refreshStrobe |-> addrDataOe && !addrDataOut[0] && !writeByteFlag && !dataInStrobe)
    else $error("refresh strobe outside address phase");

endmodule : async_bus_master
`default_nettype wire

// *** tb/bus_slave_model.sv ***
// Behavioural slave memory and interrupting device for the bus master
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model #(
  parameter int DLY = 3
) (
  // Clock
  input  wire logic        core_clk,
  // Bus from master
  input  wire logic        syncStrobe,
  input  wire logic        dataInStrobe,
  input  wire logic        dataOutStrobe,
  input  wire logic        ackChainOut,
  input  wire logic [15:0] addrDataOut,
  // Bus to master
  output var  logic        replyAck,
  output var  logic [15:0] addrDataIn,
  output var  logic        irqRequest,
  // Scenario control
  input  wire logic        mute,
  input  wire logic        irqRaise,
  input  wire logic [15:0] vector
);
  logic [15:0] regs [4];
  logic [1:0]  sel;
  logic        syncD;
  logic        go;
  int          waitN;
  // Not requesting: chain is passed on and nothing answers
  assign go = !mute && (dataOutStrobe || (dataInStrobe && (syncStrobe ||
              (ackChainOut && (irqRequest || replyAck)))));
  initial begin
    replyAck   = 1'b0;
    addrDataIn = 16'h5A5A;
    irqRequest = 1'b0;
    waitN      = 0;
    syncD      = 1'b0;
    regs       = '{default: 16'h0000};
  end
  always @(posedge core_clk) begin
    syncD <= syncStrobe;
    if (syncStrobe && !syncD) sel <= addrDataOut[2:1];
    // Raised only by scenarios that enable the device
    if (irqRaise) irqRequest <= 1'b1;
    if (go && waitN < DLY) begin
      waitN      <= waitN + 1;
      addrDataIn <= ~addrDataIn;
    end else if (go) begin
      replyAck <= 1'b1;
      if (dataOutStrobe) regs[sel] <= addrDataOut;
      else if (syncStrobe) addrDataIn <= regs[sel];
      else begin
        addrDataIn <= vector;
        irqRequest <= 1'b0;
      end
    end else begin
      // Released lines toggle so stale data never looks valid
      waitN      <= 0;
      replyAck   <= 1'b0;
      addrDataIn <= ~addrDataIn;
    end
  end
endmodule : bus_slave_model
`default_nettype wire

// *** tb/async_bus_master_tb.sv ***
// Self-checking testbench for the asynchronous bus master
`timescale 1ns/1ps
`default_nettype none
module async_bus_master_tb;
  import async_bus_pkg::*;
  localparam logic [15:0] VEC = 16'h0130;
  logic core_clk, sys_rst, cmdValid, cmdReady, doneValid, instrBoundary, resetCmd, trapValid;
  logic startValid, startConsole, addrDataOe, syncStrobe, dataInStrobe, dataOutStrobe, writeByteFlag;
  logic upperBankSelect, refreshStrobe, ackChainOut, busInit, replyAck, irqRequest, haltRequest;
  logic dcOk, powerOk, eventLine, mute, irqRaise, doneOrTrap, syncD, refD, ackD, adrFlag, adrBank, outFlag;
  logic [15:0] cmdAddr, cmdWdata, doneData, statusWord, trapVector, trapStatusLoc, addrDataIn, addrDataOut;
  logic [15:0] refAddr;
  cyc_kind_t   cmdKind;
  int          errorCnt, checked, ackCnt, refCnt, syncRise;
  assign doneOrTrap = doneValid | trapValid;

  async_bus_master #(.REFRESH_PERIOD_CYC(20000)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .doneValid(doneValid), .doneData(doneData), .instrBoundary(instrBoundary), .statusWord(statusWord),
    .resetCmd(resetCmd), .trapValid(trapValid), .trapVector(trapVector), .trapStatusLoc(trapStatusLoc),
    .startValid(startValid), .startConsole(startConsole), .addrDataIn(addrDataIn),
    .addrDataOut(addrDataOut), .addrDataOe(addrDataOe), .syncStrobe(syncStrobe),
    .dataInStrobe(dataInStrobe), .dataOutStrobe(dataOutStrobe), .writeByteFlag(writeByteFlag),
    .upperBankSelect(upperBankSelect), .refreshStrobe(refreshStrobe), .ackChainOut(ackChainOut),
    .busInit(busInit), .replyAck(replyAck), .irqRequest(irqRequest), .haltRequest(haltRequest),
    .dcOk(dcOk), .powerOk(powerOk), .eventLine(eventLine));

  bus_slave_model slave (.core_clk(core_clk), .syncStrobe(syncStrobe), .dataInStrobe(dataInStrobe),
    .dataOutStrobe(dataOutStrobe), .ackChainOut(ackChainOut), .addrDataOut(addrDataOut),
    .replyAck(replyAck), .addrDataIn(addrDataIn), .irqRequest(irqRequest), .mute(mute),
    .irqRaise(irqRaise), .vector(VEC));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Bus watcher: flags at address time and at output transfer
  always @(posedge core_clk) begin
    syncD <= syncStrobe;
    refD  <= refreshStrobe;
    ackD  <= ackChainOut;
    if (dataOutStrobe) outFlag <= writeByteFlag;
    if (ackChainOut && !ackD) ackCnt++;
    if (syncStrobe && !syncD) begin
      adrFlag <= writeByteFlag;
      adrBank <= upperBankSelect;
      syncRise++;
    end
    if (refreshStrobe && !refD) begin
      refCnt++;
      refAddr <= addrDataOut;
    end
  end

  task automatic final_report();
    if (errorCnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("MISMATCH %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : check

  task automatic wait_lv(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (s !== v && n <= lim);
    if (s !== v) begin
      check(16'h0, 16'h1, "wait limit");
      final_report();
    end
  endtask : wait_lv

  task automatic bus_op(input cyc_kind_t k, input logic [15:0] a, d, output logic [15:0] rd, output int n);
    @(posedge core_clk);
    cmdKind  <= k;
    cmdAddr  <= a;
    cmdWdata <= d;
    cmdValid <= 1'b1;
    wait_lv(cmdReady, 1'b1, 40000, n);
    @(posedge core_clk);
    cmdValid <= 1'b0;
    wait_lv(doneOrTrap, 1'b1, 3000, n);
    rd = doneData;
  endtask : bus_op

  task automatic power_up();
    int n;
    @(negedge core_clk);
    check(busInit, 1'b1, "init before dc ok");
    @(posedge core_clk);
    dcOk <= 1'b1;
    wait_lv(busInit, 1'b0, 20, n);
    @(posedge core_clk);
    powerOk <= 1'b1;
    wait_lv(startValid, 1'b1, 20, n);
    check(startConsole, 1'b1, "console start");
    @(posedge core_clk);
    haltRequest <= 1'b0;
  endtask : power_up

  task automatic rw_kinds();
    cyc_kind_t   k [5] = '{CYC_WRITE, CYC_WRITE_BYTE, CYC_READ, CYC_RMW_BYTE, CYC_RMW};
    logic [15:0] a [5] = '{16'hE002, 16'h0004, 16'hE002, 16'h0004, 16'hE002};
    logic [15:0] d [5] = '{16'h1234, 16'h00AB, 16'h0000, 16'h5500, 16'hBEEF};
    logic [15:0] e [5] = '{16'h0000, 16'h0000, 16'h1234, 16'h00AB, 16'h1234};
    logic [15:0] rd;
    int n, s0;
    for (int i = 0; i < 5; i++) begin
      s0 = syncRise;
      bus_op(k[i], a[i], d[i], rd, n);
      check(adrBank, a[i][15:13] == 3'h7, "bank select");
      check(adrFlag, k[i] inside {CYC_WRITE, CYC_WRITE_BYTE}, "address byte flag");
      check(16'(syncRise - s0), 16'h1, "one addressing");
      if (k[i] inside {CYC_READ, CYC_RMW, CYC_RMW_BYTE}) check(rd, e[i], "read data");
      if (k[i] != CYC_READ) begin
        check(slave.regs[a[i][2:1]], d[i], "written data");
        check(outFlag, k[i] inside {CYC_WRITE_BYTE, CYC_RMW_BYTE}, "output byte flag");
      end
    end
  endtask : rw_kinds

  task automatic timeout_trap();
    logic [15:0] rd;
    int n;
    mute <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      bus_op(i == 0 ? CYC_READ : CYC_WRITE, 16'h0002, 16'h0F0F, rd, n);
      check(trapValid, 1'b1, "trap");
      check(trapVector, 16'h0004, "trap vector");
      check(n >= TIMEOUT_I && n <= TIMEOUT_I + 60, 1'b1, "timeout span");
    end
    mute <= 1'b0;
  endtask : timeout_trap

  task automatic interrupts();
    int n;
    @(posedge core_clk);
    statusWord <= 16'h0080;
    irqRaise   <= 1'b1;
    ackCnt = 0;
    @(posedge core_clk);
    irqRaise <= 1'b0;
    repeat (200) @(posedge core_clk);
    check(16'(ackCnt), 16'h0, "ack while masked");
    statusWord <= 16'h0000;
    wait_lv(trapValid, 1'b1, 500, n);
    check(16'(ackCnt), 16'h1, "one acknowledge");
    check(trapVector, VEC, "vector");
    check(trapStatusLoc, VEC + 16'h0002, "vector status");
    check(irqRequest, 1'b0, "request dropped");
    @(posedge core_clk);
    eventLine <= 1'b1;
    @(posedge core_clk);
    eventLine <= 1'b0;
    wait_lv(trapValid, 1'b1, 100, n);
    check(trapVector, 16'h0040, "event location");
    check(16'(ackCnt), 16'h1, "no vector read");
  endtask : interrupts

  task automatic reset_init();
    int n;
    @(posedge core_clk);
    resetCmd <= 1'b1;
    @(posedge core_clk);
    resetCmd <= 1'b0;
    wait_lv(busInit, 1'b1, 20, n);
    wait_lv(busInit, 1'b0, 3000, n);
    check(n >= INIT_I - 2 && n <= INIT_I + 2, 1'b1, "init length");
  endtask : reset_init

  task automatic refresh_burst();
    refCnt = 0;
    for (int i = 0; i < 40000 && refCnt < 64; i++) @(posedge core_clk);
    repeat (300) @(posedge core_clk);
    check(16'(refCnt), 16'h0040, "refresh count");
    check(refAddr, 16'h007E, "last row");
  endtask : refresh_burst

  task automatic power_fail();
    int n;
    @(posedge core_clk);
    powerOk <= 1'b0;
    wait_lv(trapValid, 1'b1, 100, n);
    check(trapVector, 16'h00A6, "fail pc");
    check(trapStatusLoc, 16'h00B6, "fail status");
    @(posedge core_clk);
    dcOk <= 1'b0;
    wait_lv(busInit, 1'b1, 20, n);
    check(busInit, 1'b1, "init on dc loss");
  endtask : power_fail

  initial begin
    sys_rst = 1'b1;
    cmdValid = 1'b0;
    cmdKind = CYC_READ;
    cmdAddr = 16'h0000;
    cmdWdata = 16'h0000;
    instrBoundary = 1'b1;
    statusWord = 16'h0000;
    resetCmd = 1'b0;
    haltRequest = 1'b1;
    dcOk = 1'b0;
    powerOk = 1'b0;
    eventLine = 1'b0;
    mute = 1'b0;
    irqRaise = 1'b0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    power_up();
    rw_kinds();
    timeout_trap();
    interrupts();
    reset_init();
    refresh_burst();
    power_fail();
    final_report();
  end
endmodule : async_bus_master_tb
`default_nettype wire
